// File: hdl/dpi2c_defs.vh
// constants of the digital potentiometer serial slave front end
// assumes the includer runs ref_clk at the period given below
`ifndef DPI2C_DEFS_VH
`define DPI2C_DEFS_VH

// ************************************************************
// timing
// ************************************************************
`define DPI2C_CLK_PERIOD_NS 8
`define DPI2C_SPIKE_NS 10
`define DPI2C_SPIKE_CYCLES ((`DPI2C_SPIKE_NS + `DPI2C_CLK_PERIOD_NS - 1) / `DPI2C_CLK_PERIOD_NS)

// ************************************************************
// addressing
// ************************************************************
// arbitrary value for the fixed upper address bits
`define DPI2C_ADDR_FIXED 4'h9
`define DPI2C_GC_ADDR 7'h00
`define DPI2C_HS_CODE 5'h01
`define DPI2C_STRAP_PINS 3

// ************************************************************
// general call commands, upper six command bits
// ************************************************************
`define DPI2C_GC_WR_W0 6'h20
`define DPI2C_GC_WR_W1 6'h24
`define DPI2C_GC_WR_TERM 6'h30
`define DPI2C_GC_INC_W0 6'h21
`define DPI2C_GC_INC_W1 6'h25
`define DPI2C_GC_DEC_W0 6'h22
`define DPI2C_GC_DEC_W1 6'h26

// ************************************************************
// reset values
// ************************************************************
`define DPI2C_LINE_IDLE 1'b1

`endif

// File: hdl/dpi2c_filter.v
// two-flop synchroniser with a spike filter on one bus line
// assumes din is asynchronous to ref_clk
`timescale 1ns/1ps
`default_nettype none
`include "dpi2c_defs.vh"

module dpi2c_filter #(
  parameter [3:0] SPIKE_CYCLES = `DPI2C_SPIKE_CYCLES
) (
  input wire ref_clk,
  input wire resetn,
  input wire din,
  input wire long_en,
  output reg q
);

  reg s1;
  reg s2;
  reg [3:0] cnt;
  wire [3:0] lim;

  assign lim = long_en ? SPIKE_CYCLES : 4'h1;

  // ************************************************************
  // synchroniser
  // ************************************************************
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      s1 <= `DPI2C_LINE_IDLE;
      s2 <= `DPI2C_LINE_IDLE;
    end else begin
      s1 <= din;
      s2 <= s1;
    end
  end

  // ************************************************************
  // change only after lim stable samples
  // ************************************************************
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      q <= `DPI2C_LINE_IDLE;
      cnt <= 4'h0;
    end else if (s2 == q) begin
      cnt <= 4'h0;
    end else if (cnt >= lim - 4'h1) begin
      q <= s2;
      cnt <= 4'h0;
    end else begin
      cnt <= cnt + 4'h1;
    end
  end

endmodule // dpi2c_filter
`default_nettype wire

// File: hdl/dpi2c_slave.v
// serial slave front end of a volatile digital potentiometer
// assumes scl, sda and straps are pins; enable and tx_data share ref_clk
`timescale 1ns/1ps
`default_nettype none
`include "dpi2c_defs.vh"

module dpi2c_slave #(
  parameter STRAP_PINS = `DPI2C_STRAP_PINS
) (
  input wire ref_clk,
  input wire resetn,
  input wire scl_i,
  input wire sda_i,
  output reg sda_o,
  output reg sda_oe,
  input wire addr_strap_bit_0,
  input wire addr_strap_bit_1,
  input wire addr_strap_bit_2,
  input wire general_call_enable,
  input wire [7:0] tx_data,
  output reg rd_strobe,
  output reg hs_mode,
  output reg high_voltage_cmd_select,
  output reg addr_match,
  output reg addr_rw,
  output reg [7:0] rx_data,
  output reg rx_valid,
  output reg wiper0_wr,
  output reg wiper1_wr,
  output reg terminal_control_reg_wr,
  output reg [8:0] wr_value,
  output reg wiper0_inc,
  output reg wiper1_inc,
  output reg wiper0_dec,
  output reg wiper1_dec,
  output reg bus_collision
);

  // ************************************************************
  // states and actions
  // ************************************************************
  localparam [7:0] S_IDLE = 8'h01;
  localparam [7:0] S_ADDR = 8'h02;
  localparam [7:0] S_GCCMD = 8'h04;
  localparam [7:0] S_GCDAT = 8'h08;
  localparam [7:0] S_GCIGN = 8'h10;
  localparam [7:0] S_WRDAT = 8'h20;
  localparam [7:0] S_RDDAT = 8'h40;
  localparam [7:0] S_HSWAIT = 8'h80;

  localparam A_W0WR = 0;
  localparam A_W1WR = 1;
  localparam A_TCWR = 2;
  localparam A_W0INC = 3;
  localparam A_W1INC = 4;
  localparam A_W0DEC = 5;
  localparam A_W1DEC = 6;
  localparam A_RXV = 7;
  localparam A_ADDR = 8;

  wire scl_f, sda_f;
  reg scl_p, sda_p;
  reg [2:0] strap_s1, strap_s2;
  reg strap0_lat;
  reg [2:0] strap0_wait;
  reg [7:0] state, ack_next, dec_next;
  reg [3:0] cnt;
  reg [7:0] sh, tx_sh;
  reg m_ack, gc_msb, dec_ack, dec_hs;
  reg [8:0] act, dec_act;
  reg [2:0] gc_tgt, dec_tgt;
  wire [6:0] my_addr;
  wire start_det, stop_det, scl_rise, scl_fall;

  // ************************************************************
  // line conditioning
  // ************************************************************
  dpi2c_filter u_scl_filter (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .din(scl_i),
    .long_en(hs_mode),
    .q(scl_f)
  );
  dpi2c_filter u_sda_filter (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .din(sda_i),
    .long_en(hs_mode),
    .q(sda_f)
  );

  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      scl_p <= `DPI2C_LINE_IDLE;
      sda_p <= `DPI2C_LINE_IDLE;
    end else begin
      scl_p <= scl_f;
      sda_p <= sda_f;
    end
  end

  assign start_det = scl_f & scl_p & sda_p & ~sda_f;
  assign stop_det = scl_f & scl_p & ~sda_p & sda_f;
  assign scl_rise = scl_f & ~scl_p;
  assign scl_fall = ~scl_f & scl_p;

  // ************************************************************
  // address straps
  // ************************************************************
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      strap_s1 <= 3'h7;
      strap_s2 <= 3'h7;
      strap0_lat <= 1'b1;
      strap0_wait <= 3'h0;
      high_voltage_cmd_select <= 1'b0;
    end else begin
      strap_s1 <= {addr_strap_bit_2, addr_strap_bit_1, addr_strap_bit_0};
      strap_s2 <= strap_s1;
      high_voltage_cmd_select <= strap_s2[0];
      // stage two holds a real pin sample only from the third edge on
      strap0_wait <= {strap0_wait[1:0], 1'b1};
      if (strap0_wait == 3'h3) begin
        strap0_lat <= strap_s2[0];
      end
    end
  end

  assign my_addr = (STRAP_PINS >= 3) ? {`DPI2C_ADDR_FIXED, strap_s2[2:1], strap0_lat} :
                   (STRAP_PINS == 2) ? {`DPI2C_ADDR_FIXED, 1'b1, strap_s2[1], strap0_lat} :
                   {`DPI2C_ADDR_FIXED, 2'b11, strap0_lat};

  // ************************************************************
  // byte decision at the start of the acknowledge slot
  // ************************************************************
  always @* begin
    dec_ack = 1'b0;
    dec_hs = 1'b0;
    dec_next = S_IDLE;
    dec_act = 9'h000;
    dec_tgt = gc_tgt;
    case (state)
      S_ADDR: begin
        if (sh[7:3] == `DPI2C_HS_CODE) begin
          dec_hs = 1'b1;
          dec_next = S_HSWAIT;
        end else if (sh[7:1] == `DPI2C_GC_ADDR && !sh[0]) begin
          dec_ack = general_call_enable;
          dec_next = general_call_enable ? S_GCCMD : S_IDLE;
        end else if (sh[7:1] == my_addr) begin
          dec_ack = 1'b1;
          dec_next = sh[0] ? S_RDDAT : S_WRDAT;
          dec_act[A_ADDR] = 1'b1;
        end else begin
          dec_next = S_IDLE;
        end
      end
      S_GCCMD: begin
        dec_next = S_GCIGN;
        dec_ack = !sh[0];
        if (!sh[0]) begin
          case (sh[7:2])
            `DPI2C_GC_WR_W0: begin
              dec_next = S_GCDAT;
              dec_tgt = 3'h1;
            end
            `DPI2C_GC_WR_W1: begin
              dec_next = S_GCDAT;
              dec_tgt = 3'h2;
            end
            `DPI2C_GC_WR_TERM: begin
              dec_next = S_GCDAT;
              dec_tgt = 3'h4;
            end
            `DPI2C_GC_INC_W0: dec_act[A_W0INC] = 1'b1;
            `DPI2C_GC_INC_W1: dec_act[A_W1INC] = 1'b1;
            `DPI2C_GC_DEC_W0: dec_act[A_W0DEC] = 1'b1;
            `DPI2C_GC_DEC_W1: dec_act[A_W1DEC] = 1'b1;
            default: begin
              dec_ack = 1'b0;
              dec_next = S_IDLE;
            end
          endcase
        end else begin
          dec_next = S_IDLE;
        end
      end
      S_GCDAT: begin
        dec_ack = 1'b1;
        dec_next = S_GCIGN;
        dec_act[2:0] = gc_tgt;
      end
      S_GCIGN: begin
        dec_next = S_GCIGN;
      end
      S_WRDAT: begin
        dec_ack = 1'b1;
        dec_next = S_WRDAT;
        dec_act[A_RXV] = 1'b1;
      end
      S_RDDAT: begin
        dec_next = S_RDDAT;
      end
      default: begin
        dec_next = S_IDLE;
      end
    endcase
  end

  // ************************************************************
  // bit engine
  // ************************************************************
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state <= S_IDLE;
      ack_next <= S_IDLE;
      cnt <= 4'h0;
      sh <= 8'h00;
      tx_sh <= 8'h00;
      m_ack <= 1'b0;
      act <= 9'h000;
      gc_tgt <= 3'h0;
      gc_msb <= 1'b0;
      sda_o <= 1'b0;
      sda_oe <= 1'b0;
      hs_mode <= 1'b0;
      addr_match <= 1'b0;
      addr_rw <= 1'b0;
      rx_data <= 8'h00;
      rx_valid <= 1'b0;
      rd_strobe <= 1'b0;
      wiper0_wr <= 1'b0;
      wiper1_wr <= 1'b0;
      terminal_control_reg_wr <= 1'b0;
      wr_value <= 9'h000;
      wiper0_inc <= 1'b0;
      wiper1_inc <= 1'b0;
      wiper0_dec <= 1'b0;
      wiper1_dec <= 1'b0;
      bus_collision <= 1'b0;
    end else begin
      addr_match <= 1'b0;
      rx_valid <= 1'b0;
      rd_strobe <= 1'b0;
      wiper0_wr <= 1'b0;
      wiper1_wr <= 1'b0;
      terminal_control_reg_wr <= 1'b0;
      wiper0_inc <= 1'b0;
      wiper1_inc <= 1'b0;
      wiper0_dec <= 1'b0;
      wiper1_dec <= 1'b0;
      bus_collision <= 1'b0;
      // sda is only ever pulled low, scl is never driven
      sda_o <= 1'b0;
      if (stop_det) begin
        state <= S_IDLE;
        cnt <= 4'h0;
        sda_oe <= 1'b0;
        act <= 9'h000;
        hs_mode <= 1'b0;
      end else if (start_det) begin
        state <= S_ADDR;
        cnt <= 4'h0;
        sda_oe <= 1'b0;
        act <= 9'h000;
      end else if (state == S_HSWAIT) begin
        if ((scl_rise && !sda_f) || scl_fall) begin
          state <= S_IDLE;
          bus_collision <= 1'b1;
        end
      end else if (state != S_IDLE) begin
        if (scl_rise) begin
          if (cnt < 4'h8) begin
            sh <= {sh[6:0], sda_f};
          end
          if (cnt == 4'h8) begin
            m_ack <= ~sda_f;
          end
          if (cnt != 4'h9) begin
            cnt <= cnt + 4'h1;
          end
        end else if (scl_fall) begin
          if (cnt == 4'h8) begin
            sda_oe <= dec_ack;
            ack_next <= dec_next;
            act <= dec_act;
            gc_tgt <= dec_tgt;
            if (state == S_GCCMD) begin
              gc_msb <= sh[1];
            end
            if (dec_hs) begin
              hs_mode <= 1'b1;
            end
          end else if (cnt == 4'h9) begin
            // acknowledge slot over: commit and move on
            cnt <= 4'h0;
            act <= 9'h000;
            sda_oe <= 1'b0;
            wiper0_wr <= act[A_W0WR];
            wiper1_wr <= act[A_W1WR];
            terminal_control_reg_wr <= act[A_TCWR];
            wiper0_inc <= act[A_W0INC];
            wiper1_inc <= act[A_W1INC];
            wiper0_dec <= act[A_W0DEC];
            wiper1_dec <= act[A_W1DEC];
            rx_valid <= act[A_RXV];
            addr_match <= act[A_ADDR];
            if (act[2:0] != 3'h0) begin
              wr_value <= {gc_msb, sh};
            end
            if (act[A_RXV]) begin
              rx_data <= sh;
            end
            if (act[A_ADDR]) begin
              addr_rw <= sh[0];
            end
            if (ack_next == S_RDDAT && (state != S_RDDAT || m_ack)) begin
              state <= S_RDDAT;
              tx_sh <= {tx_data[6:0], 1'b0};
              sda_oe <= ~tx_data[7];
              rd_strobe <= 1'b1;
            end else if (state == S_RDDAT) begin
              state <= S_IDLE;
            end else begin
              state <= ack_next;
            end
          end else if (state == S_RDDAT) begin
            sda_oe <= ~tx_sh[7];
            tx_sh <= {tx_sh[6:0], 1'b0};
          end
        end
      end
    end
  end

endmodule // dpi2c_slave
`default_nettype wire

// File: verif/dpi2c_checker.sv
// port checker of the serial slave front end
// assumes it is bound onto dpi2c_slave, one clock domain
`timescale 1ns/1ps
`default_nettype none
module dpi2c_checker (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe,
  input wire logic general_call_enable,
  input wire logic hs_mode,
  input wire logic addr_match,
  input wire logic wiper0_wr,
  input wire logic wiper1_wr,
  input wire logic terminal_control_reg_wr,
  input wire logic wiper0_inc,
  input wire logic wiper1_inc,
  input wire logic wiper0_dec,
  input wire logic wiper1_dec
);
  // ****************
  // helper logic
  // ****************
  logic sda_q;
  logic [3:0] since_stop;
  wire stop_pin = scl_i & sda_i & ~sda_q;
  wire [6:0] gc = {wiper0_wr, wiper1_wr, terminal_control_reg_wr, wiper0_inc, wiper1_inc,
    wiper0_dec, wiper1_dec};
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      sda_q <= 1'b1;
      since_stop <= 4'hf;
    end else begin
      sda_q <= sda_i;
      if (stop_pin) begin
        since_stop <= 4'h0;
      end else if (since_stop != 4'hf) begin
        since_stop <= since_stop + 4'h1;
      end
    end
  end
  // ****************
  // assertions
  // ****************
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);
  sequence s_stop;
    stop_pin;
  endsequence
  sequence s_ack_held;
    $past(sda_oe) || $past(sda_oe, 2);
  endsequence
  a_sda_drive_low: assert property (!sda_o)
    else $error("sda driven high");
  a_sda_change_low: assert property ($changed(sda_oe) |-> !scl_i)
    else $error("sda moved with scl high");
  a_stop_idle: assert property (s_stop |-> ##[1:8] !hs_mode)
    else $error("stop kept high speed");
  a_hs_until_stop: assert property ($fell(hs_mode) |-> since_stop < 4'ha)
    else $error("high speed left without stop");
  a_hs_code_nack: assert property ($rose(hs_mode) |-> (!sda_oe) [*8])
    else $error("master code acknowledged");
  a_gc_enabled: assert property ((|gc) |-> general_call_enable)
    else $error("general call while disabled");
  a_gc_spacing: assert property ((|gc) |=> (!(|gc)) [*8])
    else $error("general call actions too close");
  a_addr_ack: assert property (addr_match |-> s_ack_held)
    else $error("match without acknowledge");
endmodule // dpi2c_checker

bind dpi2c_slave dpi2c_checker u_chk (
  .ref_clk(ref_clk), .resetn(resetn), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o),
  .sda_oe(sda_oe), .general_call_enable(general_call_enable), .hs_mode(hs_mode),
  .addr_match(addr_match), .wiper0_wr(wiper0_wr), .wiper1_wr(wiper1_wr),
  .terminal_control_reg_wr(terminal_control_reg_wr),
  .wiper0_inc(wiper0_inc), .wiper1_inc(wiper1_inc), .wiper0_dec(wiper0_dec),
  .wiper1_dec(wiper1_dec)
);
`default_nettype wire

// File: verif/dpi2c_master.sv
// behavioural bus master: drives scl, pulls sda low
// assumes the bench builds the pulled-up sda wire
`timescale 1ns/1ps
`default_nettype none
module dpi2c_master (
  output logic scl,
  output logic m_oe,
  input wire logic sda
);
  localparam real HALF = 62.5;
  initial begin
    scl = 1'b1;
    m_oe = 1'b0;
  end
  // ****************
  // bus conditions
  // ****************
  task automatic bitx(input logic b, output logic r);
    #16 m_oe = !b;
    #(HALF - 16) scl = 1'b1;
    #(HALF / 2) r = sda;
    #(HALF / 2) scl = 1'b0;
  endtask
  // also repeated start; clears a slave after a refusal
  task automatic start;
    #16 m_oe = 1'b0;
    #(HALF - 16) scl = 1'b1;
    #HALF m_oe = 1'b1;
    #HALF scl = 1'b0;
  endtask
  // scl pulse shorter than the high speed spike limit, scl low before
  task automatic spike;
    #20 scl = 1'b1;
    #5 scl = 1'b0;
  endtask
  task automatic stop;
    #16 m_oe = 1'b1;
    #(HALF - 16) scl = 1'b1;
    #HALF m_oe = 1'b0;
    #HALF;
  endtask
  task automatic put_byte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(b[i], r);
    bitx(1'b1, r);
    ack = !r;
  endtask
  task automatic get_byte(input logic ack, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bitx(1'b1, r);
      b[i] = r;
    end
    bitx(!ack, r);
  endtask
endmodule // dpi2c_master
`default_nettype wire

// File: verif/tb_top.sv
// self-checking bench of the serial slave front end
// assumes dpi2c_master on the bus and the checker bound to the slave
`timescale 1ns/1ps
`default_nettype none
`include "dpi2c_defs.vh"
module tb_top;
  localparam logic [7:0] WA = {`DPI2C_ADDR_FIXED, 3'b100, 1'b0};
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic general_call_enable = 1'b1;
  logic strap0 = 1'b0;
  logic [7:0] tx_data = 8'h00;
  logic [7:0] rnd = 8'h1f;
  logic a;
  logic [7:0] b;
  int failures = 0;
  int total_checks = 0;
  int coll_cnt = 0;
  int rd_cnt = 0;
  int cyc = 0;
  logic [16:0] notes[$];
  logic [5:0] gcw[3] = '{6'h20, 6'h24, 6'h30};
  logic [5:0] gci[4] = '{6'h21, 6'h25, 6'h22, 6'h26};
  logic [7:0] bad[3] = '{8'h06, 8'hfe, 8'h85};
  wire scl, m_oe, sda_o, sda_oe, rd_strobe, hs_mode, hv_cmd_sel, addr_match, addr_rw, rx_valid;
  wire wiper0_wr, wiper1_wr, terminal_control_reg_wr, wiper0_inc, wiper1_inc;
  wire wiper0_dec, wiper1_dec, bus_collision;
  wire [7:0] rx_data;
  wire [8:0] wr_value;
  wire sda = ~(sda_oe | m_oe);
  wire [7:0] ev = {rx_valid, wiper0_wr, wiper1_wr, terminal_control_reg_wr, wiper0_inc, wiper1_inc,
    wiper0_dec, wiper1_dec};
  wire [8:0] val = rx_valid ? {1'b0, rx_data} : ((|ev[6:4]) ? wr_value : 9'h000);
  always #4 ref_clk = !ref_clk;
  dpi2c_master u_mst (.scl(scl), .m_oe(m_oe), .sda(sda));
  dpi2c_slave u_dut (.ref_clk(ref_clk), .resetn(resetn), .scl_i(scl), .sda_i(sda),
    .sda_o(sda_o), .sda_oe(sda_oe), .addr_strap_bit_0(strap0), .addr_strap_bit_1(1'b0),
    .addr_strap_bit_2(1'b1), .general_call_enable(general_call_enable), .tx_data(tx_data),
    .rd_strobe(rd_strobe), .hs_mode(hs_mode), .high_voltage_cmd_select(hv_cmd_sel),
    .addr_match(addr_match), .addr_rw(addr_rw), .rx_data(rx_data), .rx_valid(rx_valid),
    .wiper0_wr(wiper0_wr), .wiper1_wr(wiper1_wr),
    .terminal_control_reg_wr(terminal_control_reg_wr), .wr_value(wr_value),
    .wiper0_inc(wiper0_inc), .wiper1_inc(wiper1_inc), .wiper0_dec(wiper0_dec),
    .wiper1_dec(wiper1_dec), .bus_collision(bus_collision));
  // ****************
  // helpers
  // ****************
  task automatic check(input logic [16:0] seen, input logic [16:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic send(input logic [7:0] v, input logic e);
    u_mst.put_byte(v, a);
    check({16'h0, a}, {16'h0, e});
  endtask
  task automatic step(input int n);
    $display("test %0d done", n);
    rnd = {rnd[6:0], rnd[7] ^ rnd[5] ^ rnd[4] ^ rnd[3]};
  endtask
  task automatic end_sim;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // oldest note against each pulse seen
  always @(negedge ref_clk) begin
    if (resetn && ev !== 8'h00) check({ev, val}, notes.size() ? notes.pop_front() : 'x);
    if (bus_collision === 1'b1) coll_cnt++;
    if (rd_strobe === 1'b1) rd_cnt++;
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 40000) begin
      failures++;
      end_sim();
    end
  end
  // ****************
  // scenarios
  // ****************
  initial begin
    repeat (2) @(posedge ref_clk);
    #1 resetn = 1'b1;
    repeat (6) @(posedge ref_clk);
    #1 strap0 = 1'b1;
    repeat (4) @(posedge ref_clk);
    check({16'h0, hv_cmd_sel}, 17'h1);
    step(0);
    notes.push_back({8'h80, 1'b0, rnd});
    u_mst.start();
    send(WA, 1'b1);
    send(rnd, 1'b1);
    u_mst.stop();
    u_mst.start();
    send(WA | 8'h02, 1'b0);
    send(WA, 1'b0);
    u_mst.start();
    send(WA, 1'b1);
    u_mst.stop();
    step(1);
    for (int i = 0; i < 7; i++) begin
      u_mst.start();
      send(8'h00, 1'b1);
      if (i < 3) begin
        notes.push_back({8'h40 >> i, rnd[0], rnd});
        send({gcw[i], rnd[0], 1'b0}, 1'b1);
        send(rnd, 1'b1);
      end else begin
        notes.push_back({8'h08 >> (i - 3), 9'h000});
        send({gci[i - 3], rnd[0], 1'b0}, 1'b1);
        send({gci[i - 3], rnd[0], 1'b0}, 1'b0);
      end
      u_mst.stop();
      rnd = {rnd[6:0], rnd[7] ^ rnd[5] ^ rnd[4] ^ rnd[3]};
    end
    step(2);
    for (int i = 0; i < 3; i++) begin
      u_mst.start();
      send(8'h00, 1'b1);
      send(bad[i], 1'b0);
      send(rnd, 1'b0);
      u_mst.stop();
    end
    @(posedge ref_clk);
    #1 general_call_enable = 1'b0;
    u_mst.start();
    send(8'h00, 1'b0);
    u_mst.stop();
    @(posedge ref_clk);
    #1 general_call_enable = 1'b1;
    step(3);
    notes.push_back({8'h80, 1'b0, rnd});
    u_mst.start();
    send({`DPI2C_HS_CODE, rnd[2:0]}, 1'b0);
    check({16'h0, hs_mode}, 17'h1);
    u_mst.start();
    u_mst.spike();
    send(WA, 1'b1);
    send(rnd, 1'b1);
    u_mst.start();
    check({16'h0, hs_mode}, 17'h1);
    send(WA, 1'b1);
    u_mst.stop();
    repeat (10) @(posedge ref_clk);
    check({16'h0, hs_mode}, 17'h0);
    u_mst.start();
    send({`DPI2C_HS_CODE, rnd[2:0]}, 1'b0);
    u_mst.bitx(1'b0, a);
    u_mst.stop();
    check(17'(coll_cnt), 17'h1);
    step(4);
    u_mst.start();
    send(8'h00, 1'b1);
    send(8'h80, 1'b1);
    repeat (4) u_mst.bitx(1'b1, a);
    u_mst.stop();
    u_mst.start();
    send(WA, 1'b1);
    repeat (3) u_mst.bitx(1'b0, a);
    u_mst.start();
    send(WA, 1'b1);
    u_mst.stop();
    step(5);
    @(posedge ref_clk);
    #1 tx_data = rnd;
    u_mst.start();
    send(WA | 8'h01, 1'b1);
    u_mst.get_byte(1'b0, b);
    check({9'h0, b}, {9'h0, rnd});
    check({16'h0, addr_rw}, 17'h1);
    check(17'(rd_cnt), 17'h1);
    u_mst.stop();
    repeat (20) @(posedge ref_clk);
    check(17'(notes.size()), 17'h0);
    step(6);
    end_sim();
  end
endmodule // tb_top
`default_nettype wire
